//--- src/pmd_port_regs.sv
// Top of the port mode decode and data register block: 20 port slots,
// a strobe register port and per-port decoded controls toward the analog side.
// Assumes all inputs synchronous to core_clk_in and single-cycle strobes.
//
// Overview of operation
// - Bits 15:12 select function; codes 0-3 digital.
// - Code 4 path output, invert bit 11, partner.
// - Code 5 DAC output, range bits 10:8.
// - Code 6 DAC drive plus ADC monitor.
// - Code 7 single-ended ADC, averaging bits 7:5.
// - Code 8 differential positive input with partner.
// - Code 9 negative input, flag and range.
// - Result 12 bits, straight binary modes 6,7.
// - Positive differential input reads two's complement.
// - Negative inputs (9, 10) read zero.
// - Twenty read/write 12-bit output codes.
`default_nettype none
module pmd_port_regs
    import pmd_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic [pmd_pkg::PMD_ADDR_W-1:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    input wire logic [pmd_pkg::PMD_NUM_PORTS-1:0] conv_valid_in,
    input wire logic [pmd_pkg::PMD_NUM_PORTS*12-1:0] conv_data_in,
    output logic [pmd_pkg::PMD_NUM_PORTS*4-1:0] port_func_out,
    output logic [pmd_pkg::PMD_NUM_PORTS-1:0] port_invert_flag_out,
    output logic [pmd_pkg::PMD_NUM_PORTS*3-1:0] port_range_out,
    output logic [pmd_pkg::PMD_NUM_PORTS*3-1:0] port_averaging_count_out,
    output logic [pmd_pkg::PMD_NUM_PORTS*5-1:0] port_partner_port_index_out,
    output logic [pmd_pkg::PMD_NUM_PORTS-1:0] port_dac_drive_out,
    output logic [pmd_pkg::PMD_NUM_PORTS-1:0] port_adc_sample_out,
    output logic [pmd_pkg::PMD_NUM_PORTS*12-1:0] port_output_code_out
);
    import pmd_pkg::*;

    logic [7:0] off;
    logic [4:0] idx;
    logic idx_ok;
    logic [PMD_NUM_PORTS-1:0] cfg_we;
    logic [PMD_NUM_PORTS-1:0] dac_we;
    logic [15:0] cfg_w [PMD_NUM_PORTS];
    logic [11:0] dac_w [PMD_NUM_PORTS];
    logic [11:0] adc_w [PMD_NUM_PORTS];
    logic [3:0] func_w [PMD_NUM_PORTS];
    logic [PMD_NUM_PORTS-1:0] flag_w;
    logic [2:0] range_w [PMD_NUM_PORTS];
    logic [2:0] avg_w [PMD_NUM_PORTS];
    logic [4:0] part_w [PMD_NUM_PORTS];
    logic [PMD_NUM_PORTS-1:0] drive_w;
    logic [PMD_NUM_PORTS-1:0] samp_w;
    logic [15:0] rdata_d;
    logic [15:0] rdata_q;
    logic [PMD_NUM_PORTS*4-1:0] func_q;
    logic [PMD_NUM_PORTS-1:0] flag_q;
    logic [PMD_NUM_PORTS*3-1:0] range_q;
    logic [PMD_NUM_PORTS*3-1:0] avg_q;
    logic [PMD_NUM_PORTS*5-1:0] part_q;
    logic [PMD_NUM_PORTS-1:0] drive_q;
    logic [PMD_NUM_PORTS-1:0] samp_q;
    logic [PMD_NUM_PORTS*12-1:0] code_q;

    // Address decode: each bank is one window of twenty words
    always_comb begin
        off = 8'h00;
        if (reg_addr_in >= PMD_DAC_BASE) begin
            off = reg_addr_in - PMD_DAC_BASE;
        end else if (reg_addr_in >= PMD_ADC_BASE) begin
            off = reg_addr_in - PMD_ADC_BASE;
        end else if (reg_addr_in >= PMD_CFG_BASE) begin
            off = reg_addr_in - PMD_CFG_BASE;
        end
    end
    assign idx = off[PMD_PIDX_W-1:0];
    assign idx_ok = (off[7:PMD_PIDX_W] == 3'h0) && (idx <= PMD_LAST_PORT)
                    && (reg_addr_in >= PMD_CFG_BASE);

    genvar g;
    generate
        for (g = 0; g < PMD_NUM_PORTS; g++) begin : g_port
            assign cfg_we[g] = reg_wr_in && idx_ok && (idx == PMD_PIDX_W'(g))
                               && (reg_addr_in < PMD_ADC_BASE);
            // Result bank ignores writes
            assign dac_we[g] = reg_wr_in && idx_ok && (idx == PMD_PIDX_W'(g))
                               && (reg_addr_in >= PMD_DAC_BASE);
            pmd_port_slot u_slot (
                .core_clk_in(core_clk_in),
                .resetn_in(resetn_in),
                .cfg_we_in(cfg_we[g]),
                .dac_we_in(dac_we[g]),
                .wdata_in(reg_wdata_in),
                .conv_valid_in(conv_valid_in[g]),
                .conv_data_in(conv_data_in[g*12 +: 12]),
                .cfg_out(cfg_w[g]),
                .dac_out(dac_w[g]),
                .adc_out(adc_w[g]),
                .func_out(func_w[g]),
                .flag_out(flag_w[g]),
                .range_out(range_w[g]),
                .avg_out(avg_w[g]),
                .partner_out(part_w[g]),
                .dac_drive_out(drive_w[g]),
                .adc_sample_out(samp_w[g])
            );
        end
    endgenerate

    // Read mux; upper bits of the data banks read as zero
    always_comb begin
        rdata_d = PMD_UNMAPPED_READ;
        if (idx_ok) begin
            if (reg_addr_in >= PMD_DAC_BASE) begin
                rdata_d = {4'h0, dac_w[idx]};
            end else if (reg_addr_in >= PMD_ADC_BASE) begin
                rdata_d = {4'h0, adc_w[idx]};
            end else begin
                rdata_d = cfg_w[idx];
            end
        end
    end

    // Read data held for the cycle after the strobe only
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_q <= PMD_UNMAPPED_READ;
        end else if (reg_rd_in) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= PMD_UNMAPPED_READ;
        end
    end

    // Registered copies of decoded controls so outputs come from flops;
    // costs one cycle of latency after a configuration write.
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            func_q <= '0;
            flag_q <= '0;
            range_q <= '0;
            avg_q <= '0;
            part_q <= '0;
            drive_q <= '0;
            samp_q <= '0;
            code_q <= '0;
        end else begin
            for (int i = 0; i < PMD_NUM_PORTS; i++) begin
                func_q[i*4 +: 4] <= func_w[i];
                flag_q[i] <= flag_w[i];
                range_q[i*3 +: 3] <= range_w[i];
                avg_q[i*3 +: 3] <= avg_w[i];
                part_q[i*5 +: 5] <= part_w[i];
                drive_q[i] <= drive_w[i];
                samp_q[i] <= samp_w[i];
                code_q[i*12 +: 12] <= dac_w[i];
            end
        end
    end

    assign reg_rdata_out = rdata_q;
    assign port_func_out = func_q;
    assign port_invert_flag_out = flag_q;
    assign port_range_out = range_q;
    assign port_averaging_count_out = avg_q;
    assign port_partner_port_index_out = part_q;
    assign port_dac_drive_out = drive_q;
    assign port_adc_sample_out = samp_q;
    assign port_output_code_out = code_q;
endmodule
`default_nettype wire

//--- src/pmd_pkg.sv
// Package for the port mode decode and data register block.
// Assumes one 50 MHz clock and a simple strobe register port.
`default_nettype none
package pmd_pkg;
    localparam int PMD_NUM_PORTS = 20;
    localparam int PMD_CFG_W = 16;
    localparam int PMD_DATA_W = 12;
    localparam int PMD_ADDR_W = 8;
    localparam int PMD_PIDX_W = 5;
    // Register index bases (one word per port)
    localparam logic [7:0] PMD_CFG_BASE = 8'h20;
    localparam logic [7:0] PMD_ADC_BASE = 8'h40;
    localparam logic [7:0] PMD_DAC_BASE = 8'h60;
    localparam logic [4:0] PMD_LAST_PORT = 5'h13;
    // Configuration word fields
    localparam int PMD_SEL_HI = 15;
    localparam int PMD_SEL_LO = 12;
    localparam int PMD_FLAG_BIT = 11;
    localparam int PMD_RANGE_HI = 10;
    localparam int PMD_RANGE_LO = 8;
    localparam int PMD_AVG_HI = 7;
    localparam int PMD_AVG_LO = 5;
    localparam int PMD_PART_HI = 4;
    localparam int PMD_PART_LO = 0;
    localparam logic [15:0] PMD_CFG_RESET = 16'h0000;
    localparam logic [11:0] PMD_DATA_RESET = 12'h000;
    localparam logic [11:0] PMD_ADC_NEG_VALUE = 12'h000;
    localparam logic [15:0] PMD_UNMAPPED_READ = 16'h0000;
    localparam logic [2:0] PMD_ZERO3 = 3'h0;
    localparam logic [4:0] PMD_ZERO5 = 5'h00;
    // Function selector codes
    localparam logic [3:0] PMD_F_HIZ = 4'h0;
    localparam logic [3:0] PMD_F_GPI = 4'h1;
    localparam logic [3:0] PMD_F_XLAT = 4'h2;
    localparam logic [3:0] PMD_F_GPO = 4'h3;
    localparam logic [3:0] PMD_F_PATH = 4'h4;
    localparam logic [3:0] PMD_F_DAC = 4'h5;
    localparam logic [3:0] PMD_F_DAC_MON = 4'h6;
    localparam logic [3:0] PMD_F_ADC_SE = 4'h7;
    localparam logic [3:0] PMD_F_ADC_POS = 4'h8;
    localparam logic [3:0] PMD_F_ADC_NEG = 4'h9;
    localparam logic [3:0] PMD_F_PSEUDO = 4'hA;
    localparam logic [3:0] PMD_F_SW_GPI = 4'hB;
    localparam logic [3:0] PMD_F_SW_REG = 4'hC;
    typedef enum logic [1:0] {
        PMD_CODE_NONE,
        PMD_CODE_STRAIGHT,
        PMD_CODE_TWOS
    } pmd_coding_e;
endpackage
`default_nettype wire

//--- src/pmd_mode_decode.sv
// Decodes one port configuration word into function and parameter fields.
// Assumes the word comes straight from the configuration register.
`default_nettype none
module pmd_mode_decode
    import pmd_pkg::*;
(
    input wire logic [15:0] cfg_in,
    output logic [3:0] func_out,
    output logic flag_out,
    output logic [2:0] range_out,
    output logic [2:0] avg_out,
    output logic [4:0] partner_out,
    output logic dac_drive_out,
    output logic adc_sample_out,
    output logic [1:0] coding_out
);
    logic [3:0] sel;
    assign sel = cfg_in[PMD_SEL_HI:PMD_SEL_LO];
    always_comb begin
        func_out = sel;
        flag_out = 1'b0;
        range_out = PMD_ZERO3;
        avg_out = PMD_ZERO3;
        partner_out = PMD_ZERO5;
        dac_drive_out = 1'b0;
        adc_sample_out = 1'b0;
        coding_out = PMD_CODE_NONE;
        // Unused parameter bits stay zero so nothing downstream sees them
        case (sel)
            PMD_F_HIZ, PMD_F_GPI, PMD_F_XLAT, PMD_F_GPO: begin
            end
            PMD_F_PATH: begin
                flag_out = cfg_in[PMD_FLAG_BIT];
                partner_out = cfg_in[PMD_PART_HI:PMD_PART_LO];
            end
            PMD_F_DAC: begin
                range_out = cfg_in[PMD_RANGE_HI:PMD_RANGE_LO];
                dac_drive_out = 1'b1;
            end
            PMD_F_DAC_MON: begin
                flag_out = cfg_in[PMD_FLAG_BIT];
                range_out = cfg_in[PMD_RANGE_HI:PMD_RANGE_LO];
                dac_drive_out = 1'b1;
                adc_sample_out = 1'b1;
                coding_out = PMD_CODE_STRAIGHT;
            end
            PMD_F_ADC_SE: begin
                flag_out = cfg_in[PMD_FLAG_BIT];
                range_out = cfg_in[PMD_RANGE_HI:PMD_RANGE_LO];
                avg_out = cfg_in[PMD_AVG_HI:PMD_AVG_LO];
                adc_sample_out = 1'b1;
                coding_out = PMD_CODE_STRAIGHT;
            end
            PMD_F_ADC_POS: begin
                flag_out = cfg_in[PMD_FLAG_BIT];
                range_out = cfg_in[PMD_RANGE_HI:PMD_RANGE_LO];
                avg_out = cfg_in[PMD_AVG_HI:PMD_AVG_LO];
                partner_out = cfg_in[PMD_PART_HI:PMD_PART_LO];
                adc_sample_out = 1'b1;
                coding_out = PMD_CODE_TWOS;
            end
            PMD_F_ADC_NEG: begin
                flag_out = cfg_in[PMD_FLAG_BIT];
                range_out = cfg_in[PMD_RANGE_HI:PMD_RANGE_LO];
            end
            PMD_F_PSEUDO: begin
                flag_out = cfg_in[PMD_FLAG_BIT];
                range_out = cfg_in[PMD_RANGE_HI:PMD_RANGE_LO];
                dac_drive_out = 1'b1;
            end
            PMD_F_SW_GPI: begin
                flag_out = cfg_in[PMD_FLAG_BIT];
                partner_out = cfg_in[PMD_PART_HI:PMD_PART_LO];
            end
            PMD_F_SW_REG: begin
            end
            default: begin
                func_out = PMD_F_HIZ;
            end
        endcase
    end
endmodule
`default_nettype wire

//--- src/pmd_port_slot.sv
// One port's storage: configuration word, output code and conversion result.
// Assumes write enables are one-cycle strobes decoded by the top.
`default_nettype none
module pmd_port_slot
    import pmd_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic cfg_we_in,
    input wire logic dac_we_in,
    input wire logic [15:0] wdata_in,
    input wire logic conv_valid_in,
    input wire logic [11:0] conv_data_in,
    output logic [15:0] cfg_out,
    output logic [11:0] dac_out,
    output logic [11:0] adc_out,
    output logic [3:0] func_out,
    output logic flag_out,
    output logic [2:0] range_out,
    output logic [2:0] avg_out,
    output logic [4:0] partner_out,
    output logic dac_drive_out,
    output logic adc_sample_out
);
    logic [15:0] cfg_q;
    logic [11:0] dac_q;
    logic [11:0] adc_q;
    logic [1:0] coding;
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_q <= PMD_CFG_RESET;
        end else if (cfg_we_in) begin
            cfg_q <= wdata_in;
        end
    end
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dac_q <= PMD_DATA_RESET;
        end else if (dac_we_in) begin
            dac_q <= wdata_in[PMD_DATA_W-1:0];
        end
    end
    pmd_mode_decode u_dec (
        .cfg_in(cfg_q),
        .func_out(func_out),
        .flag_out(flag_out),
        .range_out(range_out),
        .avg_out(avg_out),
        .partner_out(partner_out),
        .dac_drive_out(dac_drive_out),
        .adc_sample_out(adc_sample_out),
        .coding_out(coding)
    );
    // Result follows the converter only while the mode samples; coding is the
    // converter's job, this slot stores the word as delivered.
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            adc_q <= PMD_DATA_RESET;
        end else if (coding == PMD_CODE_NONE) begin
            adc_q <= PMD_ADC_NEG_VALUE;
        end else if (conv_valid_in) begin
            adc_q <= conv_data_in;
        end
    end
    assign cfg_out = cfg_q;
    assign dac_out = dac_q;
    assign adc_out = adc_q;
endmodule
`default_nettype wire

//--- test/pmd_port_regs_monitor.sv
// Checker for the port register block: port 0 decode and register read bus.
// Assumes it is bound to pmd_port_regs and sees only that module's ports.
`default_nettype none
module pmd_port_regs_monitor
    import pmd_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic [79:0] port_func_out,
    input wire logic [19:0] port_invert_flag_out,
    input wire logic [59:0] port_range_out,
    input wire logic [59:0] port_averaging_count_out,
    input wire logic [99:0] port_partner_port_index_out,
    input wire logic [19:0] port_dac_drive_out,
    input wire logic [19:0] port_adc_sample_out,
    input wire logic [239:0] port_output_code_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    logic [3:0] f0;
    logic cfg0_wr;
    assign f0 = port_func_out[3:0];
    assign cfg0_wr = reg_wr_in && (reg_addr_in == PMD_CFG_BASE);
    property p_func_valid;
        cfg0_wr && reg_wdata_in[15:12] <= 4'hC |-> ##2 f0 == $past(reg_wdata_in[15:12], 2);
    endproperty
    property p_func_undef;
        cfg0_wr && reg_wdata_in[15:12] > 4'hC |-> ##2 f0 == 4'h0;
    endproperty
    property p_dac_drive;
        port_dac_drive_out[0] == (f0 inside {4'h5, 4'h6, 4'hA});
    endproperty
    property p_adc_sample;
        port_adc_sample_out[0] == (f0 inside {4'h6, 4'h7, 4'h8});
    endproperty
    property p_avg;
        port_averaging_count_out[2:0] != 3'h0 |-> f0 inside {4'h7, 4'h8};
    endproperty
    property p_partner;
        port_partner_port_index_out[4:0] != 5'h00 |-> f0 inside {4'h4, 4'h8, 4'hB};
    endproperty
    property p_range;
        port_range_out[2:0] != 3'h0 |-> f0 inside {[4'h5:4'hA]};
    endproperty
    property p_flag;
        port_invert_flag_out[0] |-> f0 inside {4'h4, [4'h6:4'hB]};
    endproperty
    property p_rd_idle;
        !reg_rd_in |=> reg_rdata_out == 16'h0000;
    endproperty
    // Last port's code; the output copy lags one cycle, as does the read data
    property p_dac_rd;
        reg_rd_in && reg_addr_in == PMD_DAC_BASE + 8'h13
            |=> reg_rdata_out == {4'h0, port_output_code_out[239:228]};
    endproperty
    a_func_valid: assert property (p_func_valid) else $error("function code mismatch");
    a_func_undef: assert property (p_func_undef) else $error("undefined code not idle");
    a_dac_drive: assert property (p_dac_drive) else $error("dac drive decode wrong");
    a_adc_sample: assert property (p_adc_sample) else $error("adc sample decode wrong");
    a_avg: assert property (p_avg) else $error("averaging count leaks");
    a_partner: assert property (p_partner) else $error("partner index leaks");
    a_range: assert property (p_range) else $error("range field leaks");
    a_flag: assert property (p_flag) else $error("flag bit leaks");
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
    a_dac_rd: assert property (p_dac_rd) else $error("output code readback wrong");
    c_cfg_wr: cover property (cfg0_wr);
    c_adc_rd: cover property (reg_rd_in && reg_addr_in == PMD_ADC_BASE);
    c_sample: cover property (port_adc_sample_out[0]);
endmodule
bind pmd_port_regs pmd_port_regs_monitor pmd_port_regs_monitor_i (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .port_func_out(port_func_out),
    .port_invert_flag_out(port_invert_flag_out), .port_range_out(port_range_out),
    .port_averaging_count_out(port_averaging_count_out),
    .port_partner_port_index_out(port_partner_port_index_out),
    .port_dac_drive_out(port_dac_drive_out), .port_adc_sample_out(port_adc_sample_out),
    .port_output_code_out(port_output_code_out)
);
`default_nettype wire

//--- test/pmd_conv_model.sv
// Converter model: hands one coded 12-bit word to one port per request.
// Assumes requests are one-cycle pulses from the bench.
`default_nettype none
module pmd_conv_model (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic req_in,
    input wire logic [4:0] port_in,
    input wire logic [11:0] word_in,
    output logic [19:0] conv_valid_out,
    output logic [239:0] conv_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] last_q;
    // Idle lanes show the inverse of the last word, so stale data never reads as fresh
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            last_q <= 12'h000;
            conv_valid_out <= 20'h0_0000;
            conv_data_out <= '1;
        end else if (req_in) begin
            last_q <= word_in;
            conv_valid_out <= 20'h0_0001 << port_in;
            conv_data_out <= {20{~word_in}};
            conv_data_out[port_in*12 +: 12] <= word_in;
        end else begin
            conv_valid_out <= 20'h0_0000;
            conv_data_out <= {20{~last_q}};
        end
    end
endmodule
`default_nettype wire

//--- test/pmd_port_regs_tb.sv
// Self-checking bench for the port register block.
// Assumes the converter model stands in for the sampling path.
`default_nettype none
module pmd_port_regs_tb;
    import pmd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rstn = 0, wr = 0, rd = 0, req = 0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [4:0] rport = 5'h00;
    logic [11:0] rword = 12'h000;
    logic [19:0] cvalid, flag, drv, smp;
    logic [239:0] cdata, code;
    logic [79:0] func;
    logic [59:0] rng, avg;
    logic [99:0] part;
    int num_errors = 0, checks_done = 0, cycles = 0;
    pmd_conv_model pmd_conv_model_i (.core_clk_in(clk), .resetn_in(rstn), .req_in(req),
        .port_in(rport), .word_in(rword), .conv_valid_out(cvalid), .conv_data_out(cdata));
    pmd_port_regs pmd_port_regs_i (.core_clk_in(clk), .resetn_in(rstn), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .conv_valid_in(cvalid), .conv_data_in(cdata), .port_func_out(func),
        .port_invert_flag_out(flag), .port_range_out(rng), .port_averaging_count_out(avg),
        .port_partner_port_index_out(part), .port_dac_drive_out(drv),
        .port_adc_sample_out(smp), .port_output_code_out(code));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus_wr(logic [7:0] a, logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic convert(logic [4:0] p, logic [11:0] w);
        @(posedge clk);
        req <= 1'b1;
        rport <= p;
        rword <= w;
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_reset();
        logic [15:0] d;
        bus_rd(PMD_CFG_BASE, d);
        check("cfg reset", d, PMD_CFG_RESET);
        bus_rd(PMD_DAC_BASE + 8'h13, d);
        check("code reset", d, 16'h0000);
        bus_rd(PMD_ADC_BASE, d);
        check("result reset", d, 16'h0000);
        bus_rd(8'h74, d);
        check("unmapped", d, PMD_UNMAPPED_READ);
    endtask
    // Parameters ab3 give distinct values to every field, exposing swaps and leaks
    task automatic t_modes();
        logic [15:0] d;
        logic [3:0] c;
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            bus_wr(PMD_CFG_BASE, {c, 12'hab3});
            @(posedge clk);
            #1;
            check("func", {12'h000, func[3:0]}, (c <= 4'hC) ? {12'h000, c} : 16'h0000);
            check("flag", {15'h0, flag[0]}, {15'h0, c inside {4'h4, [4'h6:4'hB]}});
            check("range", {13'h0, rng[2:0]}, (c inside {[4'h5:4'hA]}) ? 16'h2 : 16'h0);
            check("avg", {13'h0, avg[2:0]}, (c inside {4'h7, 4'h8}) ? 16'h5 : 16'h0);
            check("partner", {11'h0, part[4:0]},
                (c inside {4'h4, 4'h8, 4'hB}) ? 16'h13 : 16'h0);
            check("drive", {15'h0, drv[0]}, {15'h0, c inside {4'h5, 4'h6, 4'hA}});
            check("sample", {15'h0, smp[0]}, {15'h0, c inside {4'h6, 4'h7, 4'h8}});
            bus_rd(PMD_CFG_BASE, d);
            check("cfg readback", d, {c, 12'hab3});
        end
    endtask
    task automatic t_dac();
        logic [15:0] d;
        bus_wr(PMD_DAC_BASE + 8'h13, 16'hfabc);
        bus_rd(PMD_DAC_BASE + 8'h13, d);
        check("code read", d, 16'h0abc);
        check("code out", {4'h0, code[239:228]}, 16'h0abc);
    endtask
    task automatic t_adc();
        logic [15:0] d;
        bus_wr(PMD_CFG_BASE, 16'h7100);
        convert(5'h00, 12'hfff);
        bus_rd(PMD_ADC_BASE, d);
        check("single ended", d, 16'h0fff);
        bus_wr(PMD_ADC_BASE, 16'h0123);
        bus_rd(PMD_ADC_BASE, d);
        check("result read only", d, 16'h0fff);
        bus_wr(PMD_CFG_BASE + 8'h02, 16'h8103);
        bus_wr(PMD_CFG_BASE + 8'h03, 16'h9100);
        convert(5'h02, 12'h800);
        bus_rd(PMD_ADC_BASE + 8'h02, d);
        check("positive input", d, 16'h0800);
        convert(5'h03, 12'h555);
        bus_rd(PMD_ADC_BASE + 8'h03, d);
        check("negative input", d, 16'h0000);
        bus_wr(PMD_CFG_BASE + 8'h03, 16'ha100);
        convert(5'h03, 12'h2aa);
        bus_rd(PMD_ADC_BASE + 8'h03, d);
        check("pseudo negative", d, 16'h0000);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_modes();
        t_dac();
        t_adc();
        final_report();
    end
endmodule
`default_nettype wire
